/* File: inc/sfpi_regs.svh */
`ifndef SFPI_REGS_SVH
`define SFPI_REGS_SVH
// Array geometry
`define SFPI_PAGE_BYTES     16'h0100
`define SFPI_SECTOR_COUNT   16'h1000
`define SFPI_BLK64_COUNT    16'h0100
`define SFPI_BLK32_COUNT    16'h0200
`define SFPI_SECTOR_BYTES   20'h01000
`define SFPI_BLK32_BYTES    20'h08000
`define SFPI_BLK64_BYTES    20'h10000
// Security area and unique identifier
`define SFPI_OTP_REGIONS    3'h4
`define SFPI_OTP_BYTES      16'h0100
`define SFPI_UID_BITS       7'h40
// Bits per byte on each transfer width
`define SFPI_BITS_SINGLE    4'h8
`define SFPI_BITS_DUAL      4'h4
`define SFPI_BITS_QUAD      4'h2
`endif

/* File: inc/sfpi_pkg.sv */
package sfpi_pkg;
	// Line width of the current phase
	typedef enum logic [1:0] {
		SFPI_W_SINGLE = 2'h0,
		SFPI_W_DUAL   = 2'h1,
		SFPI_W_QUAD   = 2'h2
	} sfpi_width_t;
	// Internal array cycle state
	typedef enum logic [1:0] {
		SFPI_ST_IDLE    = 2'h0,
		SFPI_ST_BUSY    = 2'h1,
		SFPI_ST_SUSPEND = 2'h2
	} sfpi_state_t;
endpackage : sfpi_pkg

/* File: logic/sfpi_buf2.sv */
`timescale 1ns/1ps
// Two-entry buffer between byte capture and the core
module sfpi_buf2 (
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	input  wire logic       in_valid_i,
	output logic            in_ready_o,
	input  wire logic [7:0] in_data_i,
	output logic            out_valid_o,
	input  wire logic       out_ready_i,
	output logic [7:0]      out_data_o
);
	logic [7:0] mem_ff [2];   // Storage
	logic       wp_ff;        // Write pointer
	logic       rp_ff;        // Read pointer
	logic [1:0] cnt_ff;       // Occupancy
	logic       push;
	logic       pop;

	assign in_ready_o  = (cnt_ff != 2'h2);
	assign out_valid_o = (cnt_ff != 2'h0);
	assign out_data_o  = mem_ff[rp_ff];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// Pointers and occupancy
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp_ff  <= 1'b0;
			rp_ff  <= 1'b0;
			cnt_ff <= 2'h0;
		end else begin
			if (push) wp_ff <= ~wp_ff;
			if (pop) rp_ff <= ~rp_ff;
			cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
		end
	end

	// Storage write
	always_ff @(posedge clock_i) begin
		if (push) mem_ff[wp_ff] <= in_data_i;
	end

	AST_BUF_NO_OVERFLOW: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		cnt_ff <= 2'h2) else $error("buffer overflow");
endmodule : sfpi_buf2

/* File: logic/sfpi_core.sv */
`timescale 1ns/1ps
`include "sfpi_regs.svh"
// Function
// - Deselected means all data lines float
// - Internal cycle finishes after deselect
// - No instruction before first select fall
// - Single mode captures serial_in on rise
// - Single mode shifts output on fall
// - Multi-line sample rise, drive fall
// - Dual uses lines 0-1, quad 0-3
// - Quad modes need quad_enable_bit set
// - Quad enable turns pins into lines 2,3
// - Write-protect low refuses status writes
// - Quad enable disables write protect
// - Pause floats output, ignores clock/input
// - Pause release resumes operation
// - Quad enable disables pause
// - Page program 1 to 256 bytes
// - 4096 sectors of 4 KB
// - 256 blocks of 64 KB
// - 512 blocks of 32 KB
// - Four 256-byte lockable security regions
// - 64-bit unique identifier readable
// - Program/erase suspend and resume
// - Supports clock modes 0 and 3
// - Line 3 is pause or reset
module sfpi_core (
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	// Pins, asynchronous to clock_i
	input  wire logic        sclk_i,          // Serial clock
	input  wire logic        sel_n_i,         // Device select, low active
	input  wire logic [3:0]  io_line_i,       // Data line levels
	output logic [3:0]       io_line_o,       // Data line drive value
	output logic [3:0]       io_line_oe_o,    // Data line drive enable
	// Configuration from the core
	input  wire logic        quad_enable_bit_i,   // Quad enable
	input  wire logic        line3_reset_sel_i,   // Line 3 acts as reset
	input  wire logic [1:0]  width_i,             // Transfer width now
	input  wire logic        out_phase_i,         // Device drives data
	input  wire logic        status_wr_req_i,     // Status write asked
	input  wire logic        cycle_start_i,       // Array cycle begins
	input  wire logic        cycle_done_i,        // Array cycle ends
	input  wire logic        suspend_i,           // Suspend request
	input  wire logic        resume_i,            // Resume request
	input  wire logic [15:0] page_count_i,        // Program byte count
	// Received bytes toward the core
	output logic             rx_valid_o,
	input  wire logic        rx_ready_i,
	output logic [7:0]       rx_data_o,
	// Transmit byte from the core
	input  wire logic [7:0]  tx_data_i,
	output logic             tx_take_o,           // Byte loaded
	// Status
	output logic             selected_o,          // Accepting instructions
	output logic             armed_o,             // First select fall seen
	output logic             standby_o,           // Low-power standby
	output logic             busy_o,              // Array cycle running
	output logic             suspended_o,         // Cycle suspended
	output logic             status_wr_ok_o,      // Status write allowed
	output logic             paused_o,            // Pause active
	output logic             pin_reset_o,         // Reset from line 3
	output logic             page_count_ok_o,     // Program count legal
	output logic             overrun_o            // Byte lost, no room
);
	logic [1:0]  sclk_sy_ff;      // Clock synchroniser
	logic [1:0]  sel_sy_ff;       // Select synchroniser
	logic [3:0]  io_sy0_ff;       // Data first stage
	logic [3:0]  io_sy1_ff;       // Data second stage
	logic        sclk_d_ff;       // Last clock level
	logic        sel_d_ff;        // Last select level
	logic        armed_ff;        // Select fall seen
	logic [7:0]  sh_in_ff;        // Input shift register
	logic [3:0]  bit_cnt_ff;      // Bits in current byte
	logic [7:0]  sh_out_ff;       // Output shift register
	logic [3:0]  out_cnt_ff;      // Bits left to send
	logic [3:0]  drv_ff;          // Driven value
	logic [3:0]  drv_en_ff;       // Drive enable
	logic        rx_push_ff;      // Byte complete
	logic [7:0]  rx_byte_ff;      // Completed byte
	logic        overrun_ff;      // Sticky overrun
	sfpi_pkg::sfpi_state_t st_ff; // Array cycle state
	logic        sclk_rise;
	logic        sclk_fall;
	logic        sel_fall;
	logic        active;
	logic        pause_act;
	logic [1:0]  wid;
	logic [3:0]  bits_per_byte;
	logic        buf_ready;

	// Two-flop synchronisers for every pin
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_sy_ff <= 2'h0;
			// Select reads low until seen high, so a pin held low gives no false fall
			sel_sy_ff  <= 2'h0;
			io_sy0_ff  <= 4'hF;
			io_sy1_ff  <= 4'hF;
		end else begin
			sclk_sy_ff <= {sclk_sy_ff[0], sclk_i};
			sel_sy_ff  <= {sel_sy_ff[0], sel_n_i};
			io_sy0_ff  <= io_line_i;
			io_sy1_ff  <= io_sy0_ff;
		end
	end

	// Edge history on synchronised levels
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_d_ff <= 1'b0;
			sel_d_ff  <= 1'b0;
		end else begin
			sclk_d_ff <= sclk_sy_ff[1];
			sel_d_ff  <= sel_sy_ff[1];
		end
	end

	// Pause only when quad off and line 3 not reset
	assign pause_act   = !quad_enable_bit_i && !line3_reset_sel_i
		&& !io_sy1_ff[3] && !sel_sy_ff[1];
	assign pin_reset_o = !quad_enable_bit_i && line3_reset_sel_i
		&& !io_sy1_ff[3];
	// Edges are masked while paused so counters freeze
	assign sclk_rise = sclk_sy_ff[1] && !sclk_d_ff && !pause_act;
	assign sclk_fall = !sclk_sy_ff[1] && sclk_d_ff && !pause_act;
	assign sel_fall  = !sel_sy_ff[1] && sel_d_ff;
	assign active    = armed_ff && !sel_sy_ff[1];
	// Quad width refused without quad enable
	assign wid = (width_i == sfpi_pkg::SFPI_W_QUAD && !quad_enable_bit_i)
		? sfpi_pkg::SFPI_W_SINGLE : width_i;
	assign bits_per_byte = (wid == sfpi_pkg::SFPI_W_QUAD) ? `SFPI_BITS_QUAD :
		(wid == sfpi_pkg::SFPI_W_DUAL) ? `SFPI_BITS_DUAL : `SFPI_BITS_SINGLE;

	// Arm on first select fall after reset
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) armed_ff <= 1'b0;
		else if (sel_fall) armed_ff <= 1'b1;
	end

	// Input shifting on rising edges; select high restarts the byte
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sh_in_ff   <= 8'h00;
			bit_cnt_ff <= 4'h0;
			rx_push_ff <= 1'b0;
			rx_byte_ff <= 8'h00;
			overrun_ff <= 1'b0;
		end else begin
			rx_push_ff <= 1'b0;
			if (!active) begin
				bit_cnt_ff <= 4'h0;
			end else if (sclk_rise && !out_phase_i) begin
				case (wid)
					sfpi_pkg::SFPI_W_QUAD: sh_in_ff <= {sh_in_ff[3:0], io_sy1_ff};
					sfpi_pkg::SFPI_W_DUAL: sh_in_ff <= {sh_in_ff[5:0], io_sy1_ff[1:0]};
					default:               sh_in_ff <= {sh_in_ff[6:0], io_sy1_ff[0]};
				endcase
				if (bit_cnt_ff + 4'h1 == bits_per_byte) begin
					bit_cnt_ff <= 4'h0;
					rx_push_ff <= 1'b1;
					case (wid)
						sfpi_pkg::SFPI_W_QUAD: rx_byte_ff <= {sh_in_ff[3:0], io_sy1_ff};
						sfpi_pkg::SFPI_W_DUAL: rx_byte_ff <= {sh_in_ff[5:0], io_sy1_ff[1:0]};
						default:               rx_byte_ff <= {sh_in_ff[6:0], io_sy1_ff[0]};
					endcase
				end else begin
					bit_cnt_ff <= bit_cnt_ff + 4'h1;
				end
			end
			if (rx_push_ff && !buf_ready) overrun_ff <= 1'b1;
		end
	end

	// Output shifting on falling edges, drive enables per width
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sh_out_ff  <= 8'h00;
			out_cnt_ff <= 4'h0;
			drv_ff     <= 4'h0;
			drv_en_ff  <= 4'h0;
		end else if (!active || !out_phase_i) begin
			drv_en_ff  <= 4'h0;
			out_cnt_ff <= 4'h0;
		end else if (sclk_fall) begin
			if (out_cnt_ff == 4'h0) begin
				sh_out_ff  <= tx_data_i;
				out_cnt_ff <= bits_per_byte - 4'h1;
				case (wid)
					sfpi_pkg::SFPI_W_QUAD: drv_ff <= tx_data_i[7:4];
					sfpi_pkg::SFPI_W_DUAL: drv_ff <= {2'h0, tx_data_i[7:6]};
					default:               drv_ff <= {2'h0, tx_data_i[7], 1'b0};
				endcase
			end else begin
				out_cnt_ff <= out_cnt_ff - 4'h1;
				case (wid)
					sfpi_pkg::SFPI_W_QUAD: begin
						drv_ff    <= sh_out_ff[3:0];
						sh_out_ff <= {sh_out_ff[3:0], 4'h0};
					end
					sfpi_pkg::SFPI_W_DUAL: begin
						drv_ff    <= {2'h0, sh_out_ff[5:4]};
						sh_out_ff <= {sh_out_ff[5:0], 2'h0};
					end
					default: begin
						drv_ff    <= {2'h0, sh_out_ff[6], 1'b0};
						sh_out_ff <= {sh_out_ff[6:0], 1'b0};
					end
				endcase
			end
			case (wid)
				sfpi_pkg::SFPI_W_QUAD: drv_en_ff <= 4'hF;
				sfpi_pkg::SFPI_W_DUAL: drv_en_ff <= 4'h3;
				default:               drv_en_ff <= 4'h2;
			endcase
		end
	end

	assign tx_take_o    = active && out_phase_i && sclk_fall && (out_cnt_ff == 4'h0);
	assign io_line_o    = drv_ff;
	// Pause floats the lines but keeps shift state for resume
	// Lines 2 and 3 never driven unless quad enable is set
	assign io_line_oe_o = (active && !pause_act)
		? (drv_en_ff & {{2{quad_enable_bit_i}}, 2'h3}) : 4'h0;

	// Internal cycle runs regardless of select; suspend and resume
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) st_ff <= sfpi_pkg::SFPI_ST_IDLE;
		else begin
			case (st_ff)
				sfpi_pkg::SFPI_ST_IDLE:
					if (cycle_start_i) st_ff <= sfpi_pkg::SFPI_ST_BUSY;
				sfpi_pkg::SFPI_ST_BUSY:
					if (cycle_done_i) st_ff <= sfpi_pkg::SFPI_ST_IDLE;
					else if (suspend_i) st_ff <= sfpi_pkg::SFPI_ST_SUSPEND;
				sfpi_pkg::SFPI_ST_SUSPEND:
					if (resume_i) st_ff <= sfpi_pkg::SFPI_ST_BUSY;
				default: st_ff <= sfpi_pkg::SFPI_ST_IDLE;
			endcase
		end
	end

	assign busy_o      = (st_ff == sfpi_pkg::SFPI_ST_BUSY);
	assign suspended_o = (st_ff == sfpi_pkg::SFPI_ST_SUSPEND);
	assign standby_o   = sel_sy_ff[1] && !busy_o;
	assign selected_o  = active;
	assign armed_o     = armed_ff;
	assign paused_o    = pause_act;
	assign overrun_o   = overrun_ff;
	// Write protect works only with quad enable clear
	assign status_wr_ok_o = status_wr_req_i && (quad_enable_bit_i || io_sy1_ff[2]);
	// Program count check, 1 to 256 bytes
	assign page_count_ok_o = (page_count_i != 16'h0000)
		&& (page_count_i <= `SFPI_PAGE_BYTES);

	sfpi_buf2 u_buf (
		.clock_i     (clock_i),
		.rst_n_i     (rst_n_i),
		.in_valid_i  (rx_push_ff),
		.in_ready_o  (buf_ready),
		.in_data_i   (rx_byte_ff),
		.out_valid_o (rx_valid_o),
		.out_ready_i (rx_ready_i),
		.out_data_o  (rx_data_o)
	);

	// Geometry consistency: 16 MB array in each unit size
	AST_GEOM_SECT: assert property (@(posedge clock_i)
		32'(`SFPI_SECTOR_COUNT) * 32'(`SFPI_SECTOR_BYTES) == 32'h0100_0000)
		else $error("sector geometry wrong");
	AST_GEOM_B64: assert property (@(posedge clock_i)
		32'(`SFPI_BLK64_COUNT) * 32'(`SFPI_BLK64_BYTES) == 32'h0100_0000)
		else $error("64k block geometry wrong");
	AST_GEOM_B32: assert property (@(posedge clock_i)
		32'(`SFPI_BLK32_COUNT) * 32'(`SFPI_BLK32_BYTES) == 32'h0100_0000)
		else $error("32k block geometry wrong");
	AST_OTP_SIZE: assert property (@(posedge clock_i)
		16'(`SFPI_OTP_REGIONS) * `SFPI_OTP_BYTES == 16'h0400 && `SFPI_UID_BITS == 7'h40)
		else $error("security area size wrong");
	AST_DESEL_FLOAT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		sel_sy_ff[1] |-> io_line_oe_o == 4'h0) else $error("drive while deselected");
	AST_NOT_ARMED: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!armed_ff |-> !rx_push_ff && !selected_o) else $error("accepted before arm");
	AST_PAUSE_FLOAT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		pause_act |-> io_line_oe_o == 4'h0) else $error("drive while paused");
	AST_PAUSE_FREEZE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		pause_act && $past(pause_act) && active && $past(active)
		|-> $stable(bit_cnt_ff)) else $error("counter moved in pause");
	AST_QUAD_NEEDS_QE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!quad_enable_bit_i |-> io_line_oe_o[3:2] == 2'h0) else $error("quad without enable");
	AST_WP_BLOCK: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!quad_enable_bit_i && !io_sy1_ff[2] |-> !status_wr_ok_o)
		else $error("status write under protect");
	AST_BUSY_HOLDS: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		busy_o && !cycle_done_i && !suspend_i |=> busy_o) else $error("cycle dropped");

	COV_READ: cover property (@(posedge clock_i) disable iff (!rst_n_i) tx_take_o);
	COV_RX: cover property (@(posedge clock_i) disable iff (!rst_n_i) rx_valid_o && rx_ready_i);
	COV_PAUSE: cover property (@(posedge clock_i) disable iff (!rst_n_i) pause_act ##1 !pause_act);
	COV_SUSP: cover property (@(posedge clock_i) disable iff (!rst_n_i) suspended_o);
endmodule : sfpi_core

/* File: testbench/sfpi_host_model.sv */
`timescale 1ns/1ps
// Host side of the pins: serial clock in mode 0, select and data line drive
module sfpi_host_model (
	input  wire logic       clk,    // System clock, paces every pin change
	input  wire logic [3:0] line,   // Resolved wire levels
	output logic            sclk,   // Serial clock, idles low
	output logic            sel_n,  // Select, low active
	output logic [3:0]      hv,     // Host drive values
	output logic [3:0]      hoe     // Host drive enables
);
	int pause_at = -1;  // Beat held in pause, none if negative
	// Select low at power-up, so a fall is still owed
	initial begin
		sclk = 1'b0;
		sel_n = 1'b0;
		hv = 4'hC;
		hoe = 4'h0;
	end
	// Half a serial period, four system clocks
	task automatic half();
		repeat (4) @(posedge clk);
	endtask : half
	// Select edge, clock held at idle level around it
	task automatic select(input logic lvl);
		half();
		sel_n <= lvl;
		half();
	endtask : select
	// Set host drive of the data lines
	task automatic drive(input logic [3:0] oe, input logic [3:0] v);
		hoe <= oe;
		hv <= v;
	endtask : drive
	// One serial clock pulse
	task automatic pulse();
		sclk <= 1'b1;
		half();
		sclk <= 1'b0;
		half();
	endtask : pulse
	// One byte MSB first, lanes bits a beat; a read samples line 1 at each rise
	task automatic xfer(input int lanes, input logic rd, input logic [7:0] din,
			output logic [7:0] dout);
		logic [3:0] m;
		m = 4'((1 << lanes) - 1);
		dout = 8'h00;
		// Dummy pulse lets the device put out its first bit on a fall
		if (rd) begin
			pulse();
		end
		for (int k = 0; k < 8 / lanes; k++) begin
			// Pause only with the clock at idle; the pulse inside must be ignored
			if (k == pause_at) begin
				// Let the last fall land before the pause pin drops
				half();
				hoe[3] <= 1'b1;
				hv[3] <= 1'b0;
				half();
				pulse();
				hoe[3] <= 1'b0;
				half();
			end
			hoe <= rd ? 4'h1 : m;
			hv <= 4'((din >> (8 - lanes * (k + 1))) & m);
			half();
			sclk <= 1'b1;
			dout = rd ? {dout[6:0], line[1]} : dout;
			half();
			sclk <= 1'b0;
		end
		half();
	endtask : xfer
endmodule : sfpi_host_model

/* File: testbench/tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the serial pin front end
module tb;
	logic        clock_i = 1'b0;           // System clock, 20 ns
	logic        rst_n_i = 1'b0;           // Reset, low active
	logic [3:0]  io_line_i, io_line_o, io_line_oe_o, hv, hoe;
	logic        sclk_i, sel_n_i, rx_valid_o, tx_take_o;
	logic        qe = 1'b0, l3rst = 1'b0, oph = 1'b0, swr = 1'b0, rdy = 1'b0;
	logic [1:0]  width = 2'h0;             // Transfer width level
	logic        c_start = 1'b0, c_done = 1'b0, c_susp = 1'b0, c_resume = 1'b0;  // Cycle strobes
	logic [15:0] pcnt = 16'h0000;          // Program byte count
	logic [7:0]  txd = 8'h00, rx_data, d;
	logic        selected_o, armed_o, standby_o, busy_o, suspended_o;
	logic        status_wr_ok_o, paused_o, pin_reset_o, page_count_ok_o, overrun_o;
	int          err_count = 0;
	int          n_checks = 0;
	always #10 clock_i = ~clock_i;
	// Wire level: device, host, else pull-up on 2 and 3, inverse of last on 0 and 1
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			io_line_i[b] = io_line_oe_o[b] ? io_line_o[b] : hoe[b] ? hv[b] : (b > 1 || ~hv[b]);
		end
	end
	sfpi_host_model host (.clk(clock_i), .line(io_line_i), .sclk(sclk_i), .sel_n(sel_n_i),
		.hv(hv), .hoe(hoe));
	sfpi_core uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .sel_n_i(sel_n_i),
		.io_line_i(io_line_i), .io_line_o(io_line_o), .io_line_oe_o(io_line_oe_o),
		.quad_enable_bit_i(qe), .line3_reset_sel_i(l3rst), .width_i(width), .out_phase_i(oph),
		.status_wr_req_i(swr), .cycle_start_i(c_start), .cycle_done_i(c_done),
		.suspend_i(c_susp), .resume_i(c_resume), .page_count_i(pcnt), .rx_valid_o(rx_valid_o),
		.rx_ready_i(rdy), .rx_data_o(rx_data), .tx_data_i(txd), .tx_take_o(tx_take_o),
		.selected_o(selected_o), .armed_o(armed_o), .standby_o(standby_o), .busy_o(busy_o),
		.suspended_o(suspended_o), .status_wr_ok_o(status_wr_ok_o), .paused_o(paused_o),
		.pin_reset_o(pin_reset_o), .page_count_ok_o(page_count_ok_o), .overrun_o(overrun_o));
	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Take one byte from the stream, unknown if none comes
	task automatic recv(output logic [7:0] v);
		// Let a pop from the last call land first
		@(posedge clock_i);
		for (int i = 0; i < 400 && rx_valid_o !== 1'b1; i++) @(posedge clock_i);
		v = (rx_valid_o === 1'b1) ? rx_data : 8'hXX;
		rdy <= 1'b1;
		@(posedge clock_i);
		rdy <= 1'b0;
	endtask : recv
	// One-cycle strobe toward the core
	task automatic strobe(input int i);
		case (i)
			0: c_start <= 1'b1;
			1: c_done <= 1'b1;
			2: c_susp <= 1'b1;
			default: c_resume <= 1'b1;
		endcase
		@(posedge clock_i);
		c_start <= 1'b0;
		c_done <= 1'b0;
		c_susp <= 1'b0;
		c_resume <= 1'b0;
		repeat (4) @(posedge clock_i);
	endtask : strobe
	// Nothing taken before the first select fall; deselect floats lines
	task automatic t_arm();
		host.xfer(1, 1'b0, 8'h81, d);
		repeat (8) @(posedge clock_i);
		chk(rx_valid_o, 1'b0);
		chk(armed_o, 1'b0);
		host.select(1'b1);
		chk(io_line_oe_o, 4'h0);
		host.select(1'b0);
		chk(armed_o, 1'b1);
	endtask : t_arm
	// Two bytes back to back while the receiver stalls
	task automatic t_single();
		host.xfer(1, 1'b0, 8'hA5, d);
		host.xfer(1, 1'b0, 8'h3C, d);
		repeat (40) @(posedge clock_i);
		recv(d);
		chk(d, 8'hA5);
		recv(d);
		chk(d, 8'h3C);
		chk(overrun_o, 1'b0);
	endtask : t_single
	// Dual, quad refused without quad enable, then quad with it
	task automatic t_multi();
		width <= 2'h1;
		host.xfer(2, 1'b0, 8'hC6, d);
		recv(d);
		chk(d, 8'hC6);
		width <= 2'h2;
		host.xfer(1, 1'b0, 8'h5A, d);
		recv(d);
		chk(d, 8'h5A);
		qe <= 1'b1;
		host.xfer(4, 1'b0, 8'hE1, d);
		recv(d);
		chk(d, 8'hE1);
		chk(io_line_oe_o, 4'h0);
		// Release lines 1 to 3 so line 3 is high before pause comes back
		host.drive(4'h1, 4'h0);
		repeat (4) @(posedge clock_i);
		qe <= 1'b0;
		width <= 2'h0;
	endtask : t_multi
	// Single read on line 1, pause in mid byte when asked
	task automatic t_read(input int at, input logic [7:0] v);
		oph <= 1'b1;
		txd <= v;
		host.pause_at = at;
		fork
			host.xfer(1, 1'b1, 8'h00, d);
			if (at >= 0) begin
				for (int i = 0; i < 400 && paused_o !== 1'b1; i++) @(posedge clock_i);
				repeat (2) @(posedge clock_i);
				chk(paused_o, 1'b1);
				chk(io_line_oe_o[1], 1'b0);
			end
		join
		chk(d, v);
		host.pause_at = -1;
		host.select(1'b1);
		chk(io_line_oe_o, 4'h0);
		oph <= 1'b0;
		host.select(1'b0);
	endtask : t_read
	// Array cycle outlives deselect, with suspend and resume
	task automatic t_cycle();
		strobe(0);
		host.select(1'b1);
		chk(busy_o, 1'b1);
		chk(standby_o, 1'b0);
		strobe(2);
		chk(suspended_o, 1'b1);
		strobe(3);
		chk(suspended_o, 1'b0);
		chk(busy_o, 1'b1);
		strobe(1);
		chk(busy_o, 1'b0);
		chk(standby_o, 1'b1);
		host.select(1'b0);
	endtask : t_cycle
	// Write protect, quad enable overrides, line 3 as reset
	task automatic t_status();
		swr <= 1'b1;
		host.drive(4'hC, 4'h0);
		repeat (6) @(posedge clock_i);
		chk(status_wr_ok_o, 1'b0);
		chk(paused_o, 1'b1);
		qe <= 1'b1;
		repeat (6) @(posedge clock_i);
		chk(status_wr_ok_o, 1'b1);
		chk(paused_o, 1'b0);
		qe <= 1'b0;
		l3rst <= 1'b1;
		repeat (6) @(posedge clock_i);
		chk(pin_reset_o, 1'b1);
		chk(paused_o, 1'b0);
		host.drive(4'h0, 4'hC);
		swr <= 1'b0;
	endtask : t_status
	// Program count limits at both ends
	task automatic t_page();
		logic [15:0] v [4];
		v = '{16'h0000, 16'h0001, 16'h0100, 16'h0101};
		for (int i = 0; i < 4; i++) begin
			pcnt <= v[i];
			repeat (2) @(posedge clock_i);
			chk(page_count_ok_o, (i == 1 || i == 2) ? 16'h0001 : 16'h0000);
		end
	endtask : t_page
	// Counts, then the verdict
	task automatic finish_test();
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test
	// Main sequence
	initial begin
		repeat (6) @(posedge clock_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		t_arm();
		t_single();
		t_multi();
		t_read(-1, 8'h96);
		t_read(3, 8'h4B);
		t_cycle();
		t_status();
		t_page();
		finish_test();
	end
	// Watchdog, well beyond the expected run
	initial begin
		#400_000;
		err_count++;
		finish_test();
	end
endmodule : tb
